/* File: core/phyirq_pkg.sv */
// Purpose: shared constants and types of the management register slice
// Assumes: 100 MHz core clock, 5-bit management register address
// Notes:   extended registers are reached through the debug index/window pair
package phyirq_pkg;
	// ==========================================================
	// widths and addresses
	localparam int          DATA_W        = 16;
	localparam int          ADDR_W        = 5;
	localparam int          TMR_W         = 28;
	localparam int          FIFO_W        = 9;
	localparam int          FIFO_D        = 16;
	localparam logic [4:0]  REG_STATUS    = 5'h11;
	localparam logic [4:0]  REG_MASK      = 5'h12;
	localparam logic [4:0]  REG_FLAGS     = 5'h13;
	localparam logic [4:0]  REG_FALLBACK  = 5'h14;
	localparam logic [4:0]  REG_RXERR     = 5'h15;
	localparam logic [4:0]  REG_DBG_IDX   = 5'h1e;
	localparam logic [4:0]  REG_DBG_WIN   = 5'h1f;
	localparam logic [15:0] EXT_SLEEP     = 16'h0027;
	localparam logic [15:0] EXT_USER_BYTE = 16'h009f;
	localparam logic [15:0] EXT_CFG_A     = 16'h00a0;
	localparam logic [15:0] EXT_CFG_LEN   = 16'h00a1;
	localparam logic [15:0] EXT_CFG_BURST = 16'h00a2;
	// ==========================================================
	// field positions
	localparam int ST_RESOLVED = 11;
	localparam int ST_DOWNGRD  = 5;
	localparam int ST_TXPAUSE  = 3;
	localparam int ST_RXPAUSE  = 2;
	localparam int EV_ANERR    = 15;
	localparam int EV_UNUSED   = 9;
	localparam int EV_DOWNGRD  = 5;
	localparam int FB_EN       = 5;
	localparam int FB_LIM_HI   = 4;
	localparam int FB_LIM_LO   = 2;
	localparam int FB_BYP      = 1;
	localparam int SL_EN       = 15;
	localparam int SL_PULSE    = 13;
	localparam int SL_SPARE    = 12;
	localparam int CA_CHK      = 15;
	localparam int CA_GATE     = 14;
	localparam int CA_BYP      = 13;
	localparam int CA_GEN      = 12;
	localparam int CA_PRM_HI   = 11;
	localparam int CA_PRM_LO   = 8;
	localparam int CA_IPG_HI   = 7;
	localparam int CA_IPG_LO   = 4;
	localparam int CA_FORCE    = 3;
	localparam int CA_CRC      = 2;
	localparam int CA_PAY_HI   = 1;
	localparam int CA_PAY_LO   = 0;
	// ==========================================================
	// reset values and fixed codes
	localparam logic [15:0] FALLBACK_RST = 16'h082c;
	localparam logic [15:0] SLEEP_RST    = 16'h2000;
	localparam logic [15:0] CFG_A_RST    = 16'h68d0;
	localparam logic [15:0] LEN_RST      = 16'h0040;
	localparam logic [15:0] BURST_RST    = 16'h0000;
	localparam logic [15:0] CNT_MAX      = 16'hffff;
	localparam logic [3:0]  MIN_FIELD    = 4'h2;
	localparam logic [3:0]  RETRY_EXTRA  = 4'h2;
	localparam logic [1:0]  FCS_LAST     = 2'h3;
	localparam logic [31:0] FIXED_PAT    = 32'h5aa55aa5;
	localparam logic [31:0] CRC_POLY     = 32'hedb88320;
	localparam logic [31:0] CRC_INIT     = 32'hffffffff;
	localparam logic [7:0]  PRE_BYTE     = 8'h55;
	localparam logic [7:0]  SFD_BYTE     = 8'hd5;
	localparam logic [7:0]  LFSR_SEED    = 8'h01;
	localparam logic [7:0]  LFSR_TAPS    = 8'hb8;
	localparam logic [1:0]  PAY_INC      = 2'h0;
	localparam logic [1:0]  PAY_RAND     = 2'h1;
	localparam logic [1:0]  PAY_FIXED    = 2'h2;
	// ==========================================================
	// timing
	localparam int CLK_PERIOD_NS  = 10;
	localparam int STABLE_TIME_MS = 2500;
	localparam int STABLE_CYC     = STABLE_TIME_MS * (1000000 / CLK_PERIOD_NS);
	// ==========================================================
	// state machines
	typedef enum logic [1:0] {SLP_AWAKE, SLP_WAIT, SLP_ASLEEP} phyirq_slp_type;
	typedef enum logic [2:0] {GEN_IDLE, GEN_PRE, GEN_DATA, GEN_FCS, GEN_GAP} phyirq_gen_type;
endpackage

/* File: core/phyirq_regs.sv */
// Purpose: interrupt, fallback, error count, sleep and self-test register slice
// Assumes: management accesses arrive as one-cycle strobes synchronous to core_clk
// Notes:   the generator stream passes a 16-word FIFO before the transmit mux
//
// How it works
// - pause results reported only after negotiation; zero when speed forced
// - mask bit one lets same-position event flag signal an interrupt
// - flags for negotiation error, speed, duplex, page, link, temperature, mse
// - flags for wake, downgrade, crc, serdes link, polarity and jabber
// - any of six negotiation faults raises the negotiation error flag
// - downgrade enabled by default; written value applies at software reset
// - copper-to-fiber modes force downgrade off at software reset
// - downgrade after retry limit plus two failed attempts
// - link shorter than 2.5 s counts as failure unless bypassed
// - read value captured at read start and held stable
// - receive error tally counts rx_er rises under rx_dv, saturates, fast modes
// - debug index selects extended register reached through data window
// - sleep entered, front end off, after cable absent for timer period
// - while asleep a periodic line pulse is sent when enabled
// - asleep bit and sleep state field are readable
// - pll kept on in sleep only when keep bit is one
// - checker enable turns on both receive and transmit checkers
// - self-test clocks gated when idle and gating enabled
// - bypass one sends pin data, zero sends generated packets
// - burst zero runs continuously, else stops and self-clears enable
// - preamble length field below two is ignored
// - gap length field below two is ignored
// - burst size register gives packets per burst
// - packet length register defaults to sixty-four
// - payload selector picks increment, random, fixed pattern or user byte
// - force bit sends without link; corrupt bit sends bad crc
`timescale 1ns/10ps

// ==========================================================
// generator stream buffer
module phyirq_fifo #(
	parameter int W = 8,
	parameter int D = 16
) (
	// clock and reset
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	input  wire logic         core_ce,
	// fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(D);
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0]       wp;
		logic [AW-1:0]       rp;
		logic [AW:0]         cnt;
	} phyirq_fifo_type;
	phyirq_fifo_type s, n;
	logic push, pop;

	// honest flags straight from the occupancy count
	assign in_ready  = (s.cnt != (AW+1)'(D));
	assign out_valid = (s.cnt != '0);
	assign out_data  = s.mem[s.rp];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// pointer and count update
	always_comb begin
		n = s;
		if (push) begin
			n.mem[s.wp] = in_data;
			n.wp        = (s.wp == AW'(D-1)) ? '0 : s.wp + 1'b1;
		end
		if (pop) begin
			n.rp = (s.rp == AW'(D-1)) ? '0 : s.rp + 1'b1;
		end
		n.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else if (core_ce) begin
			s <= n;
		end
	end
endmodule

// ==========================================================
// register slice top
module phyirq_regs #(
	parameter int STABLE_TICKS = phyirq_pkg::STABLE_CYC,
	parameter int UNPLUG_TICKS = 1000000,
	parameter int PULSE_TICKS  = 100000
) (
	// clock, reset, enable
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	input  wire logic        core_ce,
	// management register port
	input  wire logic        mgmt_wr,
	input  wire logic        mgmt_rd,
	input  wire logic [4:0]  mgmt_addr,
	input  wire logic [15:0] mgmt_wdata,
	output logic [15:0]      mgmt_rdata_r,
	output logic             mgmt_rvalid_r,
	// event sources and negotiation status
	input  wire logic [15:0] evt_pulse,
	input  wire logic [5:0]  an_err_cause,
	input  wire logic        an_complete,
	input  wire logic        speed_forced,
	input  wire logic        pause_tx_res,
	input  wire logic        pause_rx_res,
	output logic             irq_r,
	// software reset and speed fallback
	input  wire logic        sw_reset,
	input  wire logic        copper_fiber_forced_mode,
	input  wire logic        copper_fiber_auto_mode,
	input  wire logic        an_attempt_fail,
	input  wire logic        link_up,
	output logic             downgrade_r,
	// receive error monitor
	input  wire logic        rx_er,
	input  wire logic        rx_dv,
	input  wire logic        speed_counts,
	// sleep
	input  wire logic        cable_present,
	input  wire logic        pll_keep_in,
	output logic             afe_off_r,
	output logic             pll_off_r,
	output logic             line_pulse_r,
	// self-test and transmit path
	input  wire logic [7:0]  mac_txd,
	input  wire logic        mac_tx_en,
	input  wire logic        tx_ready,
	output logic [7:0]       tx_data_r,
	output logic             tx_en_r,
	output logic             rx_chk_en_r,
	output logic             tx_chk_en_r,
	output logic             selftest_gate_r
);
	import phyirq_pkg::*;

	typedef struct packed {
		logic [15:0]    mask, flags, rxerr, dbg_idx, rdata, cfg_a, len, burst, cnt, pkt;
		logic           irq, rvalid, rx_er_q, link_q, downgraded, downgrade;
		logic           fb_en, fb_byp, eff_en, eff_byp;
		logic [2:0]     fb_lim, eff_lim;
		logic [3:0]     attempts, prm_eff, ipg_eff;
		logic [TMR_W-1:0] stab, sl_cnt;
		logic           sl_en, sl_pulse, sl_spare, afe_off, pll_off, line_pulse;
		phyirq_slp_type sl_st;
		phyirq_gen_type gen_st;
		logic [7:0]     user, lfsr, tx_data;
		logic [31:0]    crc;
		logic           tx_en, rx_chk, tx_chk, gate;
	} phyirq_state_type;

	phyirq_state_type s, n;
	logic [1:0]        rst_q;
	logic              rst_n;
	logic              push_v, push_en, f_ready, f_valid, f_pop;
	logic [7:0]        push_byte;
	logic [FIFO_W-1:0] f_data;
	logic [31:0]       fcs;
	logic [15:0]       ext_q, rd_mux;
	logic              link_fail;

	// two-stage release of the asynchronous reset
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_q <= 2'b00;
		end else begin
			rst_q <= {rst_q[0], 1'b1};
		end
	end
	assign rst_n = rst_q[1];

	// bytewise reflected crc32 step
	function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
		logic [31:0] r;
		r = c ^ {24'h000000, d};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	phyirq_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.core_ce   (core_ce),
		.in_valid  (push_v),
		.in_ready  (f_ready),
		.in_data   ({push_en, push_byte}),
		.out_valid (f_valid),
		.out_ready (f_pop),
		.out_data  (f_data)
	);
	// generated stream drains only in test mode
	assign f_pop = !s.cfg_a[CA_BYP] && tx_ready;
	// bad-crc mode sends the uninverted register so the check fails
	assign fcs   = s.cfg_a[CA_CRC] ? s.crc : ~s.crc;

	// extended register read through the debug window
	always_comb begin
		case (s.dbg_idx)
			EXT_SLEEP:     ext_q = {s.sl_en, pll_keep_in, s.sl_pulse, s.sl_spare, 6'h00,
			                        (s.sl_st == SLP_ASLEEP), 1'b0, 4'(s.sl_st)};
			EXT_USER_BYTE: ext_q = {8'h00, s.user};
			EXT_CFG_A:     ext_q = s.cfg_a;
			EXT_CFG_LEN:   ext_q = s.len;
			EXT_CFG_BURST: ext_q = s.burst;
			default:       ext_q = 16'h0000;
		endcase
		case (mgmt_addr)
			REG_STATUS: begin
				rd_mux = 16'h0000;
				rd_mux[ST_RESOLVED] = an_complete || speed_forced;
				rd_mux[ST_DOWNGRD]  = s.downgraded;
				rd_mux[ST_TXPAUSE]  = pause_tx_res && an_complete && !speed_forced;
				rd_mux[ST_RXPAUSE]  = pause_rx_res && an_complete && !speed_forced;
			end
			REG_MASK:     rd_mux = s.mask;
			REG_FLAGS:    rd_mux = s.flags;
			REG_FALLBACK: begin
				rd_mux = FALLBACK_RST;
				rd_mux[FB_EN] = s.fb_en;
				rd_mux[FB_LIM_HI:FB_LIM_LO] = s.fb_lim;
				rd_mux[FB_BYP] = s.fb_byp;
			end
			REG_RXERR:    rd_mux = s.rxerr;
			REG_DBG_IDX:  rd_mux = s.dbg_idx;
			REG_DBG_WIN:  rd_mux = ext_q;
			default:      rd_mux = 16'h0000;
		endcase
	end

	// generator byte source, one byte per accepted push
	always_comb begin
		push_v    = 1'b0;
		push_en   = 1'b1;
		push_byte = 8'h00;
		case (s.gen_st)
			GEN_PRE: begin
				push_v    = 1'b1;
				push_byte = (s.cnt[3:0] == s.prm_eff - 1'b1) ? SFD_BYTE : PRE_BYTE;
			end
			GEN_DATA: begin
				push_v = 1'b1;
				case (s.cfg_a[CA_PAY_HI:CA_PAY_LO])
					PAY_INC:   push_byte = s.cnt[7:0];
					PAY_RAND:  push_byte = s.lfsr;
					PAY_FIXED: push_byte = 8'(FIXED_PAT >> {~s.cnt[1:0], 3'b000});
					default:   push_byte = s.user;
				endcase
			end
			GEN_FCS: begin
				push_v    = 1'b1;
				push_byte = 8'(fcs >> {s.cnt[1:0], 3'b000});
			end
			GEN_GAP: begin
				push_v  = 1'b1;
				push_en = 1'b0;
			end
			default: push_v = 1'b0;
		endcase
	end

	assign link_fail = an_attempt_fail || (s.link_q && !link_up && !s.eff_byp &&
	                   (s.stab < TMR_W'(STABLE_TICKS)));

	// next state of the whole slice
	always_comb begin
		n           = s;
		n.rvalid    = 1'b0;
		n.downgrade = 1'b0;
		n.line_pulse = 1'b0;
		// sticky flags: a new event beats a clear by read in the same cycle
		if (mgmt_rd && mgmt_addr == REG_FLAGS) begin
			n.flags = 16'h0000;
		end
		n.flags = n.flags | (evt_pulse & ~(16'h0001 << EV_UNUSED));
		n.flags[EV_ANERR] = n.flags[EV_ANERR] | (|an_err_cause);
		// speed fallback, settings applied at software reset
		n.link_q = link_up;
		n.stab   = !link_up ? '0 : (s.stab == '1 ? s.stab : s.stab + 1'b1);
		if (s.link_q && s.stab >= TMR_W'(STABLE_TICKS)) begin
			n.attempts = '0;
		end
		if (s.eff_en && link_fail) begin
			if (s.attempts + 1'b1 >= {1'b0, s.eff_lim} + RETRY_EXTRA) begin
				n.attempts   = '0;
				n.downgrade  = 1'b1;
				n.downgraded = 1'b1;
				n.flags[EV_DOWNGRD] = 1'b1;
			end else begin
				n.attempts = s.attempts + 1'b1;
			end
		end
		if (sw_reset) begin
			n.eff_en  = s.fb_en && !copper_fiber_forced_mode && !copper_fiber_auto_mode;
			n.eff_lim = s.fb_lim;
			n.eff_byp = s.fb_byp;
			n.attempts   = '0;
			n.downgraded = 1'b0;
		end
		// receive error tally on each rising rx_er inside a frame
		n.rx_er_q = rx_er;
		if (speed_counts && rx_dv && rx_er && !s.rx_er_q && s.rxerr != CNT_MAX) begin
			n.rxerr = s.rxerr + 1'b1;
		end
		// sleep controller
		case (s.sl_st)
			SLP_AWAKE: begin
				n.sl_cnt = '0;
				if (s.sl_en && !cable_present) begin
					n.sl_st = SLP_WAIT;
				end
			end
			SLP_WAIT: begin
				n.sl_cnt = s.sl_cnt + 1'b1;
				if (!s.sl_en || cable_present) begin
					n.sl_st = SLP_AWAKE;
				end else if (s.sl_cnt >= TMR_W'(UNPLUG_TICKS - 1)) begin
					n.sl_st  = SLP_ASLEEP;
					n.sl_cnt = '0;
				end
			end
			SLP_ASLEEP: begin
				n.sl_cnt = s.sl_cnt + 1'b1;
				if (!s.sl_en || cable_present) begin
					n.sl_st = SLP_AWAKE;
				end else if (s.sl_cnt >= TMR_W'(PULSE_TICKS - 1)) begin
					n.sl_cnt     = '0;
					n.line_pulse = s.sl_pulse;
				end
			end
			default: n.sl_st = SLP_AWAKE;
		endcase
		n.afe_off = (n.sl_st == SLP_ASLEEP);
		n.pll_off = (n.sl_st == SLP_ASLEEP) && !pll_keep_in;
		// packet generator; stalls whenever the buffer is full
		case (s.gen_st)
			GEN_IDLE: begin
				n.cnt = '0;
				n.crc = CRC_INIT;
				if (!s.cfg_a[CA_GEN]) begin
					n.pkt = '0;
				end else if (link_up || s.cfg_a[CA_FORCE]) begin
					n.gen_st = GEN_PRE;
				end
			end
			GEN_PRE: if (f_ready) begin
				n.cnt = s.cnt + 1'b1;
				if (s.cnt[3:0] == s.prm_eff - 1'b1) begin
					n.gen_st = GEN_DATA;
					n.cnt    = '0;
				end
			end
			GEN_DATA: if (f_ready) begin
				n.crc  = crc_step(s.crc, push_byte);
				n.lfsr = {s.lfsr[6:0], ^(s.lfsr & LFSR_TAPS)};
				n.cnt  = s.cnt + 1'b1;
				if (s.cnt + 1'b1 >= s.len) begin
					n.gen_st = GEN_FCS;
					n.cnt    = '0;
				end
			end
			GEN_FCS: if (f_ready) begin
				n.cnt = s.cnt + 1'b1;
				if (s.cnt[1:0] == FCS_LAST) begin
					n.gen_st = GEN_GAP;
					n.cnt    = '0;
				end
			end
			GEN_GAP: if (f_ready) begin
				n.cnt = s.cnt + 1'b1;
				if (s.cnt[3:0] == s.ipg_eff - 1'b1) begin
					n.gen_st = GEN_IDLE;
					n.pkt    = s.pkt + 1'b1;
					if (s.burst != '0 && s.pkt + 1'b1 == s.burst) begin
						n.cfg_a[CA_GEN] = 1'b0;
						n.pkt = '0;
					end
				end
			end
			default: n.gen_st = GEN_IDLE;
		endcase
		// management writes
		if (mgmt_wr) begin
			case (mgmt_addr)
				REG_MASK: n.mask = mgmt_wdata;
				REG_FALLBACK: begin
					n.fb_en  = mgmt_wdata[FB_EN];
					n.fb_lim = mgmt_wdata[FB_LIM_HI:FB_LIM_LO];
					n.fb_byp = mgmt_wdata[FB_BYP];
				end
				REG_DBG_IDX: n.dbg_idx = mgmt_wdata;
				REG_DBG_WIN: begin
					case (s.dbg_idx)
						EXT_SLEEP: begin
							n.sl_en    = mgmt_wdata[SL_EN];
							n.sl_pulse = mgmt_wdata[SL_PULSE];
							n.sl_spare = mgmt_wdata[SL_SPARE];
						end
						EXT_USER_BYTE: n.user = mgmt_wdata[7:0];
						EXT_CFG_A: begin
							n.cfg_a = mgmt_wdata;
							if (mgmt_wdata[CA_PRM_HI:CA_PRM_LO] >= MIN_FIELD) begin
								n.prm_eff = mgmt_wdata[CA_PRM_HI:CA_PRM_LO];
							end
							if (mgmt_wdata[CA_IPG_HI:CA_IPG_LO] >= MIN_FIELD) begin
								n.ipg_eff = mgmt_wdata[CA_IPG_HI:CA_IPG_LO];
							end
						end
						EXT_CFG_LEN:   n.len   = mgmt_wdata;
						EXT_CFG_BURST: n.burst = mgmt_wdata;
						default:       n.user  = s.user;
					endcase
				end
				default: n.mask = s.mask;
			endcase
		end
		// read data captured once at the start of the read
		if (mgmt_rd) begin
			n.rdata  = rd_mux;
			n.rvalid = 1'b1;
		end
		n.irq    = |(n.flags & n.mask);
		n.rx_chk = n.cfg_a[CA_CHK];
		n.tx_chk = n.cfg_a[CA_CHK];
		n.gate   = n.cfg_a[CA_GATE] && !n.cfg_a[CA_CHK] && n.cfg_a[CA_BYP] && !n.cfg_a[CA_GEN];
		// transmit mux: pins in normal mode, buffered stream in test mode
		if (s.cfg_a[CA_BYP]) begin
			n.tx_data = mac_txd;
			n.tx_en   = mac_tx_en;
		end else begin
			n.tx_data = f_data[7:0];
			n.tx_en   = f_valid && tx_ready && f_data[FIFO_W-1];
		end
	end

	// single state register; reset values come from the package
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s          <= '0;
			s.fb_en    <= FALLBACK_RST[FB_EN];
			s.fb_lim   <= FALLBACK_RST[FB_LIM_HI:FB_LIM_LO];
			s.eff_en   <= FALLBACK_RST[FB_EN];
			s.eff_lim  <= FALLBACK_RST[FB_LIM_HI:FB_LIM_LO];
			s.sl_pulse <= SLEEP_RST[SL_PULSE];
			s.cfg_a    <= CFG_A_RST;
			s.prm_eff  <= CFG_A_RST[CA_PRM_HI:CA_PRM_LO];
			s.ipg_eff  <= CFG_A_RST[CA_IPG_HI:CA_IPG_LO];
			s.len      <= LEN_RST;
			s.burst    <= BURST_RST;
			s.lfsr     <= LFSR_SEED;
			s.crc      <= CRC_INIT;
			s.sl_st    <= SLP_AWAKE;
			s.gen_st   <= GEN_IDLE;
		end else if (core_ce) begin
			s <= n;
		end
	end

	assign mgmt_rdata_r    = s.rdata;
	assign mgmt_rvalid_r   = s.rvalid;
	assign irq_r           = s.irq;
	assign downgrade_r     = s.downgrade;
	assign afe_off_r       = s.afe_off;
	assign pll_off_r       = s.pll_off;
	assign line_pulse_r    = s.line_pulse;
	assign tx_data_r       = s.tx_data;
	assign tx_en_r         = s.tx_en;
	assign rx_chk_en_r     = s.rx_chk;
	assign tx_chk_en_r     = s.tx_chk;
	assign selftest_gate_r = s.gate;

	// ==========================================================
	// assertions
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence seq_flag_read;
		core_ce && mgmt_rd && mgmt_addr == REG_FLAGS;
	endsequence
	sequence seq_evt14;
		core_ce && evt_pulse[14];
	endsequence
	AST_PAUSE_FORCED: assert property (core_ce && mgmt_rd && mgmt_addr == REG_STATUS && speed_forced |=> mgmt_rdata_r[3:2] == 2'b00) else $error("pause bits not zero when forced");
	AST_MASK_OFF: assert property (core_ce && s.mask == 16'h0000 && !mgmt_wr |=> !irq_r) else $error("irq with empty mask");
	AST_SET_WINS: assert property (seq_flag_read and seq_evt14 |=> s.flags[14]) else $error("event lost on clear");
	AST_ANERR: assert property (core_ce && (|an_err_cause) |=> s.flags[EV_ANERR]) else $error("negotiation error not flagged");
	AST_IRQ_ON: assert property (core_ce && |(s.flags & s.mask) && !mgmt_rd && !mgmt_wr |=> irq_r) else $error("irq missing");
	AST_RXERR_SAT: assert property (core_ce && s.rxerr == CNT_MAX |=> s.rxerr == CNT_MAX) else $error("rx error tally wrapped");
	AST_RXERR_MODE: assert property (!speed_counts |=> $stable(s.rxerr)) else $error("tally moved outside fast modes");
	AST_READ_HELD: assert property (!mgmt_rd [*2] |-> $stable(mgmt_rdata_r)) else $error("read data moved");
	AST_GATE: assert property (core_ce && !mgmt_wr && s.cfg_a[CA_GATE] && !s.cfg_a[CA_CHK] && s.cfg_a[CA_BYP] && !s.cfg_a[CA_GEN] |=> selftest_gate_r) else $error("clocks not gated");
	AST_BYPASS: assert property (core_ce && s.cfg_a[CA_BYP] |=> tx_en_r == $past(mac_tx_en)) else $error("bypass path broken");
	AST_PLL: assert property (pll_off_r && $past(core_ce) |-> afe_off_r && !$past(pll_keep_in)) else $error("pll off while kept");
endmodule

/* File: sim/phyirq_mgr.sv */
// Purpose: station manager model issuing register cycles
// Assumes: strobes change at the falling edge only
// Notes:   released write data is inverted so stale values never pass
`timescale 1ns/10ps
// ==========================================================
// manager model
module phyirq_mgr (
	// register port
	input  wire logic        core_clk,
	input  wire logic [15:0] mgmt_rdata_r,
	output logic             mgmt_wr,
	output logic             mgmt_rd,
	output logic [4:0]       mgmt_addr,
	output logic [15:0]      mgmt_wdata
);
	// idle bus at time zero
	initial begin
		{mgmt_wr, mgmt_rd, mgmt_addr, mgmt_wdata} = '0;
	end
	// one-cycle write strobe, data scrambled once released
	task automatic wr(input logic [4:0] a, input logic [15:0] v);
		@(negedge core_clk);
		{mgmt_wr, mgmt_addr, mgmt_wdata} = {1'b1, a, v};
		@(negedge core_clk);
		mgmt_wr = 1'b0;
		mgmt_wdata = ~v;
	endtask
	// answer is sampled half a cycle after the taking edge
	task automatic rd(input logic [4:0] a, output logic [15:0] v);
		@(negedge core_clk);
		{mgmt_rd, mgmt_addr} = {1'b1, a};
		@(negedge core_clk);
		mgmt_rd = 1'b0;
		v = mgmt_rdata_r;
	endtask
	// extended access: index first, then the window
	task automatic xw(input logic [15:0] a, input logic [15:0] v);
		wr(5'h1e, a);
		wr(5'h1f, v);
	endtask
	task automatic xr(input logic [15:0] a, output logic [15:0] v);
		wr(5'h1e, a);
		rd(5'h1f, v);
	endtask
endmodule

/* File: sim/phyirq_regs_tb.sv */
// Purpose: self-checking bench of the register slice
// Assumes: inputs change at the falling edge
// Notes:   short timer parameters keep the run brief
`timescale 1ns/10ps
// ==========================================================
// bench
module phyirq_regs_tb;
	import phyirq_pkg::*;
	logic core_clk = 0, arst_n = 0, rx_er = 0, rx_dv = 0, cp = 1, af = 0, tr = 0, mte = 0;
	logic ce = 1, swr = 0, ffm = 0, fam = 0, lu = 0, sc = 1, pk = 0;
	logic mgmt_wr, mgmt_rd, rv, irq_r, dg, afe, pll, lp, tx_en_r, rc, tc, sg;
	logic [4:0] mgmt_addr;
	logic [15:0] mgmt_wdata, mgmt_rdata_r, evt = 0, d, e;
	logic [5:0] cause = 0;
	logic [3:0] st = 0;
	logic [7:0] txd = 0, tx_data_r;
	int num_errors = 0, checked = 0, cyc = 0, dgs = 0, lps = 0, seed = 32'h4bd6;
	phyirq_mgr u_m (.core_clk(core_clk), .mgmt_rdata_r(mgmt_rdata_r), .mgmt_wr(mgmt_wr),
		.mgmt_rd(mgmt_rd), .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata));
	phyirq_regs #(.STABLE_TICKS(50), .UNPLUG_TICKS(20), .PULSE_TICKS(10)) u_phyirq_regs (
		.core_clk(core_clk), .arst_n(arst_n), .core_ce(ce), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd),
		.mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata), .mgmt_rdata_r(mgmt_rdata_r), .mgmt_rvalid_r(rv),
		.evt_pulse(evt), .an_err_cause(cause), .an_complete(st[0]), .speed_forced(st[1]),
		.pause_tx_res(st[3]), .pause_rx_res(st[2]), .irq_r(irq_r), .sw_reset(swr),
		.copper_fiber_forced_mode(ffm), .copper_fiber_auto_mode(fam), .an_attempt_fail(af),
		.link_up(lu), .downgrade_r(dg), .rx_er(rx_er), .rx_dv(rx_dv), .speed_counts(sc),
		.cable_present(cp), .pll_keep_in(pk), .afe_off_r(afe), .pll_off_r(pll), .line_pulse_r(lp),
		.mac_txd(txd), .mac_tx_en(mte), .tx_ready(tr), .tx_data_r(tx_data_r), .tx_en_r(tx_en_r),
		.rx_chk_en_r(rc), .tx_chk_en_r(tc), .selftest_gate_r(sg));
	// clock, pulse counters and hang limit
	initial forever #5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cyc++;
		dgs += (dg === 1'b1);
		lps += (lp === 1'b1);
		if (cyc == 6000) begin
			num_errors++;
			wrap_up();
		end
	end
	task automatic chk(input logic [15:0] s, input logic [15:0] x);
		checked++;
		if (s !== x) begin
			num_errors++;
			$display("[FAIL] %0t seen %h exp %h", $time, s, x);
		end
	endtask
	function automatic logic [15:0] ef(input logic [15:0] p, input logic [5:0] c);
		return (p & 16'hfdff) | {|c, 15'h0};
	endfunction
	task automatic wrap_up();
		$display("checked %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (2) @(negedge core_clk);
		arst_n = 1;
		repeat (3) @(negedge core_clk);
		u_m.rd(REG_FALLBACK, d);
		chk(d, FALLBACK_RST);
		chk(rv, 1);
		u_m.xr(EXT_CFG_A, d);
		chk(d, 16'h68d0);
		chk(sg, 1);
		u_m.xr(EXT_SLEEP, d);
		chk(d, 16'h2000);
		u_m.wr(5'h03, 16'hffff);
		u_m.rd(5'h03, d);
		chk(d, 16'h0000);
		for (int i = 0; i < 4; i++) begin
			st = $random(seed);
			u_m.rd(REG_STATUS, d);
			chk(d & 16'h000c, (st[0] & !st[1]) ? {12'h0, st[3:2], 2'h0} : 16'h0);
		end
		$display("test status done");
		d = $random(seed);
		u_m.wr(REG_MASK, d);
		u_m.rd(REG_MASK, e);
		chk(e, d);
		e = $random(seed);
		{evt, cause} = {e, 6'h21};
		@(negedge core_clk);
		{evt, cause} = '0;
		@(negedge core_clk);
		chk({15'h0, irq_r}, {15'h0, |(d & ef(e, 6'h21))});
		u_m.rd(REG_FLAGS, d);
		chk(d, ef(e, 6'h21));
		// an event landing in the clearing read must survive it
		fork
			u_m.rd(REG_FLAGS, d);
			begin
				@(negedge core_clk);
				evt = 16'h4000;
				@(negedge core_clk);
				evt = 16'h0000;
			end
		join
		chk(d, 16'h0000);
		u_m.rd(REG_FLAGS, d);
		chk(d, 16'h4000);
		// one failed attempt per pass, rx_er held a varying time
		for (int i = 0; i < 5; i++) begin
			chk(dgs, 0);
			{rx_er, rx_dv, af} = 3'b111;
			@(negedge core_clk);
			af = 0;
			repeat (i) @(negedge core_clk);
			rx_er = 0;
			@(negedge core_clk);
		end
		rx_er = 1;
		rx_dv = 0;
		@(negedge core_clk);
		rx_er = 0;
		u_m.rd(REG_RXERR, d);
		chk(d, 16'h0005);
		chk(dgs, 1);
		{sc, rx_dv, rx_er} = 3'b011;
		@(negedge core_clk);
		{sc, rx_dv, rx_er} = 3'b100;
		u_m.rd(REG_RXERR, d);
		chk(d, 16'h0005);
		u_m.rd(REG_FLAGS, d);
		chk(d, 16'h0020);
		// fiber modes at software reset switch the fallback off
		{ffm, swr} = 2'b11;
		@(negedge core_clk);
		{ffm, fam} = 2'b01;
		@(negedge core_clk);
		{fam, swr, af} = 3'b001;
		repeat (6) @(negedge core_clk);
		af = 0;
		@(negedge core_clk);
		chk(dgs, 1);
		$display("test events done");
		for (int i = 0; i < 4; i++) begin
			{txd, mte} = {8'($random(seed)), 1'b1};
			@(negedge core_clk);
			chk({7'h0, tx_en_r, tx_data_r}, {7'h0, mte, txd});
		end
		// a low clock enable freezes the transmit register
		{ce, txd} = {1'b0, ~txd};
		@(negedge core_clk);
		chk({8'h0, tx_data_r}, {8'h0, ~txd});
		ce = 1;
		mte = 0;
		u_m.xw(EXT_SLEEP, 16'ha000);
		cp = 0;
		for (int i = 0; i < 40 && afe !== 1'b1; i++) @(negedge core_clk);
		chk({afe, pll}, 2'b11);
		pk = 1;
		lps = 0;
		u_m.xr(EXT_SLEEP, d);
		chk(d, 16'he022);
		repeat (12) @(negedge core_clk);
		chk({afe, pll}, 2'b10);
		chk(lps > 0, 1);
		cp = 1;
		$display("test sleep done");
		u_m.xw(EXT_CFG_BURST, 16'h0001);
		u_m.xw(EXT_CFG_A, 16'hd22a);
		repeat (30) @(negedge core_clk);
		chk({rc, tc, sg, tx_en_r}, 4'b1100);
		tr = 1;
		for (int i = 0; i < 20 && tx_en_r !== 1'b1; i++) @(negedge core_clk);
		for (int i = 0; i < 4; i++) begin
			chk(tx_data_r, 32'h55d55aa5 >> (24 - 8 * i) & 8'hff);
			@(negedge core_clk);
		end
		repeat (120) @(negedge core_clk);
		u_m.xr(EXT_CFG_A, d);
		chk(d, 16'hc22a);
		$display("test generator done");
		wrap_up();
	end
endmodule
